// File: src/rss_top.sv
`include "rss_defs.svh"
`default_nettype none
module rss_top #(
   parameter int unsigned POWERUP_DELAY_TIMER_RC_CYCLES =
      (`RSS_POWERUP_DELAY_TIMER_MS * `RSS_NS_PER_MS) / `RSS_RC_PERIOD_NS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // supply comparators and pins
   input wire logic supply_ok_i,
   input wire logic brownout_low_i,
   input wire logic master_clear_pin_n_i,
   input wire logic crystal_in_pin_i,
   // core status
   input wire logic watchdog_expired_i,
   input wire logic core_sleeping_i,
   // reset and clock outputs
   output logic core_hold_o,
   output logic regs_reset_o,
   output logic wake_o,
   output logic sys_tick_o,
   output logic sys_slow_o,
   output logic crystal_out_pin_o,
   output logic crystal_out_pin_oe_n_o
);

   // ----------------------------------------
   // derived counts
   // ----------------------------------------
   localparam int unsigned RC_DIV =
      (`RSS_RC_PERIOD_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS;
   localparam int unsigned BOD_CYC =
      (`RSS_BOD_MIN_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS;
   localparam int unsigned MASTER_CLEAR_PIN_CYC =
      (`RSS_MASTER_CLEAR_PIN_MIN_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS;
   localparam int unsigned FAST_DIV = `RSS_CLK_HZ / `RSS_FAST_HZ;
   localparam int unsigned SLOW_DIV = `RSS_CLK_HZ / `RSS_SLOW_HZ;

   function automatic logic is_xtal(input rss_pkg::rss_osc_mode_t m);
      is_xtal = (m == rss_pkg::OSC_LP) || (m == rss_pkg::OSC_XT) ||
                (m == rss_pkg::OSC_HS);
   endfunction

   function automatic logic is_rc(input rss_pkg::rss_osc_mode_t m);
      is_rc = (m == rss_pkg::OSC_INTERNAL_RC_MODE_IO) || (m == rss_pkg::OSC_INTERNAL_RC_MODE_CLK) ||
              (m == rss_pkg::OSC_ER_IO) || (m == rss_pkg::OSC_ER_CLK);
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   rss_pkg::rss_cfg_t cfg_r;
   rss_pkg::rss_sflags_t sfl_r;
   rss_pkg::rss_state_t state_r, st_nxt;
   rss_pkg::rss_cause_t cause_r, cause_nxt;
   logic [3:0] sync1_r, sync2_r;
   logic xtal_d_r;
   logic [11:0] bod_cnt_r;
   logic bod_trip_r;
   logic [6:0] master_clear_pin_cnt_r;
   logic master_clear_pin_act_r;
   logic [5:0] rc_cnt_r;
   logic rc_tick_r;
   logic [10:0] sys_cnt_r;
   logic [1:0] q_cnt_r;
   logic [19:0] tmr_r, tmr_nxt;
   logic speed_select_bit_r, por_flag_r, bod_flag_r;
   logic ev_por, ev_bod, ev_master_clear_pin, ev_wdt, ev_wake;
   logic supply_ok_s, bo_low_s, master_clear_pin_n_s, xtal_s;
   logic bo_wait, ost_need, slow_sel, clk_drive, xtal_rise;
   logic req, wr_stb;
   logic [9:0] idx;
   logic [31:0] rd_nxt;

   assign supply_ok_s = sync2_r[0];
   assign bo_low_s = sync2_r[1];
   assign master_clear_pin_n_s = sync2_r[2];
   assign xtal_s = sync2_r[3];
   assign xtal_rise = xtal_s & ~xtal_d_r;
   assign bo_wait = cfg_r.bod_en & bo_low_s;
   assign slow_sel = is_rc(cfg_r.mode) & ~speed_select_bit_r;
   assign clk_drive = (cfg_r.mode == rss_pkg::OSC_INTERNAL_RC_MODE_CLK) ||
                      (cfg_r.mode == rss_pkg::OSC_ER_CLK);
   // settling follows power-on and wake in crystal modes only, and brown-out only while the power-up delay timer is enabled
   assign ost_need = is_xtal(cfg_r.mode) &&
                     (cause_r == rss_pkg::CS_POR || cause_r == rss_pkg::CS_BOD ||
                      cause_r == rss_pkg::CS_WAKE);
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
   assign idx = wb_adr_i[11:2];

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         xtal_d_r <= 1'b0;
      end
      else
      begin
         sync1_r <= {crystal_in_pin_i, master_clear_pin_n_i, brownout_low_i, supply_ok_i};
         sync2_r <= sync1_r;
         xtal_d_r <= xtal_s;
      end
   end

   // ----------------------------------------
   // brown-out duration filter
   // ----------------------------------------
   // dips shorter than the minimum are ignored by design
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !cfg_r.bod_en || !bo_low_s)
      begin
         bod_cnt_r <= 12'h000;
         bod_trip_r <= 1'b0;
      end
      else if (bod_cnt_r == 12'(BOD_CYC - 1))
         bod_trip_r <= 1'b1;
      else
         bod_cnt_r <= bod_cnt_r + 12'h001;
   end

   // ----------------------------------------
   // master clear glitch filter
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         master_clear_pin_cnt_r <= 7'h00;
         master_clear_pin_act_r <= 1'b0;
      end
      else if (~master_clear_pin_n_s == master_clear_pin_act_r)
         master_clear_pin_cnt_r <= 7'h00;
      else if (master_clear_pin_cnt_r == 7'(MASTER_CLEAR_PIN_CYC - 1))
      begin
         master_clear_pin_cnt_r <= 7'h00;
         master_clear_pin_act_r <= ~master_clear_pin_n_s;
      end
      else
         master_clear_pin_cnt_r <= master_clear_pin_cnt_r + 7'h01;
   end

   // ----------------------------------------
   // internal RC tick for the power-up delay
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i || rc_cnt_r == 6'(RC_DIV - 1))
         rc_cnt_r <= 6'h00;
      else
         rc_cnt_r <= rc_cnt_r + 6'h01;
      rc_tick_r <= !rst_i && rc_cnt_r == 6'(RC_DIV - 1);
   end

   // ----------------------------------------
   // system clock enable and quarter clock
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sys_cnt_r <= 11'h000;
         sys_tick_o <= 1'b0;
         q_cnt_r <= 2'h0;
      end
      else
      begin
         sys_tick_o <= 1'b0;
         if (sys_cnt_r >= (slow_sel ? 11'(SLOW_DIV - 1) : 11'(FAST_DIV - 1)))
         begin
            sys_cnt_r <= 11'h000;
            sys_tick_o <= 1'b1;
            q_cnt_r <= q_cnt_r + 2'h1;
         end
         else
            sys_cnt_r <= sys_cnt_r + 11'h001;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sys_slow_o <= 1'b0;
         crystal_out_pin_o <= 1'b0;
         crystal_out_pin_oe_n_o <= 1'b1;
      end
      else
      begin
         sys_slow_o <= slow_sel;
         crystal_out_pin_o <= clk_drive & q_cnt_r[1];
         crystal_out_pin_oe_n_o <= ~clk_drive;
      end
   end

   // ----------------------------------------
   // reset sequencer
   // ----------------------------------------
   always_comb
   begin
      st_nxt = state_r;
      cause_nxt = cause_r;
      tmr_nxt = tmr_r;
      ev_por = 1'b0;
      ev_bod = 1'b0;
      ev_master_clear_pin = 1'b0;
      ev_wdt = 1'b0;
      ev_wake = 1'b0;
      if (!supply_ok_s)
      begin
         st_nxt = rss_pkg::ST_POR;
         cause_nxt = rss_pkg::CS_POR;
         ev_por = 1'b1;
      end
      else if (bod_trip_r && state_r != rss_pkg::ST_POR && state_r != rss_pkg::ST_BOD)
      begin
         st_nxt = rss_pkg::ST_BOD;
         cause_nxt = rss_pkg::CS_BOD;
         ev_bod = 1'b1;
      end
      else
      begin
         unique case (state_r)
            rss_pkg::ST_POR:
               st_nxt = rss_pkg::ST_BOD;
            rss_pkg::ST_BOD:
               if (!bo_wait)
               begin
                  tmr_nxt = 20'h00000;
                  if (!cfg_r.powerup_delay_timer_dis)
                     st_nxt = rss_pkg::ST_POWERUP_DELAY_TIMER;
                  else if (ost_need && cause_r != rss_pkg::CS_BOD)
                     st_nxt = rss_pkg::ST_OST;
                  else
                     st_nxt = rss_pkg::ST_HOLD;
               end
            rss_pkg::ST_POWERUP_DELAY_TIMER:
               if (rc_tick_r)
               begin
                  if (tmr_r == 20'(POWERUP_DELAY_TIMER_RC_CYCLES - 1))
                  begin
                     tmr_nxt = 20'h00000;
                     st_nxt = ost_need ? rss_pkg::ST_OST : rss_pkg::ST_HOLD;
                  end
                  else
                     tmr_nxt = tmr_r + 20'h00001;
               end
            rss_pkg::ST_OST:
               if (xtal_rise)
               begin
                  if (tmr_r == 20'(`RSS_OST_CYCLES - 1))
                     st_nxt = rss_pkg::ST_HOLD;
                  else
                     tmr_nxt = tmr_r + 20'h00001;
               end
            rss_pkg::ST_HOLD:
               // no timer runs here; release waits only for master clear to go inactive and for the brown-out wait to clear
               if (!master_clear_pin_act_r && !bo_wait)
                  st_nxt = rss_pkg::ST_RUN;
            rss_pkg::ST_RUN:
               if (master_clear_pin_act_r)
               begin
                  st_nxt = rss_pkg::ST_HOLD;
                  cause_nxt = core_sleeping_i ? rss_pkg::CS_MASTER_CLEAR_PIN_SLP
                                              : rss_pkg::CS_MASTER_CLEAR_PIN_RUN;
                  ev_master_clear_pin = 1'b1;
               end
               else if (watchdog_expired_i && core_sleeping_i)
               begin
                  tmr_nxt = 20'h00000;
                  cause_nxt = rss_pkg::CS_WAKE;
                  st_nxt = is_xtal(cfg_r.mode) ? rss_pkg::ST_OST
                                               : rss_pkg::ST_RUN;
                  ev_wake = 1'b1;
               end
               else if (watchdog_expired_i)
               begin
                  st_nxt = rss_pkg::ST_HOLD;
                  cause_nxt = rss_pkg::CS_WDT;
                  ev_wdt = 1'b1;
               end
            default:
               st_nxt = rss_pkg::ST_POR;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= rss_pkg::ST_POR;
         cause_r <= rss_pkg::CS_POR;
         tmr_r <= 20'h00000;
      end
      else
      begin
         state_r <= st_nxt;
         cause_r <= cause_nxt;
         tmr_r <= tmr_nxt;
      end
   end

   // ----------------------------------------
   // reset outputs
   // ----------------------------------------
   // retained registers are simply not wired to regs_reset_o
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         core_hold_o <= 1'b1;
         regs_reset_o <= 1'b1;
         wake_o <= 1'b0;
      end
      else
      begin
         core_hold_o <= st_nxt != rss_pkg::ST_RUN;
         regs_reset_o <= st_nxt != rss_pkg::ST_RUN &&
                         cause_nxt != rss_pkg::CS_WAKE;
         wake_o <= st_nxt == rss_pkg::ST_RUN && cause_nxt == rss_pkg::CS_WAKE &&
                   (state_r != rss_pkg::ST_RUN || ev_wake);
      end
   end

   // ----------------------------------------
   // power control flags
   // ----------------------------------------
   // hardware events are applied after the bus write so they win
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         speed_select_bit_r <= 1'b1;
         por_flag_r <= 1'b0;
         bod_flag_r <= 1'b0;
      end
      else
      begin
         if (wr_stb && idx == `RSS_POWER_CONTROL_STATUS_IDX)
         begin
            speed_select_bit_r <= wb_dat_i[`RSS_POWER_CONTROL_STATUS_SPEED_SELECT_BIT];
            por_flag_r <= wb_dat_i[`RSS_POWER_CONTROL_STATUS_POR];
            bod_flag_r <= wb_dat_i[`RSS_POWER_CONTROL_STATUS_BOD];
         end
         if (ev_por || ev_bod || ev_master_clear_pin || ev_wdt)
            speed_select_bit_r <= 1'b1;
         if (ev_por)
            por_flag_r <= 1'b0;
         if (ev_bod)
            bod_flag_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // timeout and sleep flags, configuration
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sfl_r <= '{to: 1'b1, pd: 1'b1};
      else
      begin
         if (wr_stb && idx == `RSS_CAUSE_IDX)
         begin
            sfl_r.to <= wb_dat_i[`RSS_CAUSE_TO];
            sfl_r.pd <= wb_dat_i[`RSS_CAUSE_PD];
         end
         if (ev_por || ev_bod)
            sfl_r <= '{to: 1'b1, pd: 1'b1};
         else if (ev_master_clear_pin && core_sleeping_i)
            sfl_r <= '{to: 1'b1, pd: 1'b0};
         else if (ev_wdt)
            sfl_r.to <= 1'b0;
         else if (ev_wake)
            sfl_r <= '{to: 1'b0, pd: 1'b0};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cfg_r <= rss_pkg::rss_cfg_t'(`RSS_CFG_RST);
      else if (wr_stb && idx == `RSS_CFG_IDX)
         cfg_r <= rss_pkg::rss_cfg_t'(wb_dat_i[4:0]);
   end

   // ----------------------------------------
   // wishbone read and acknowledge
   // ----------------------------------------
   always_comb
   begin
      rd_nxt = 32'h00000000;
      unique case (idx)
         `RSS_POWER_CONTROL_STATUS_IDX:
         begin
            rd_nxt[`RSS_POWER_CONTROL_STATUS_SPEED_SELECT_BIT] = speed_select_bit_r;
            rd_nxt[`RSS_POWER_CONTROL_STATUS_POR] = por_flag_r;
            rd_nxt[`RSS_POWER_CONTROL_STATUS_BOD] = bod_flag_r;
         end
         `RSS_CFG_IDX:
            rd_nxt[4:0] = cfg_r;
         `RSS_CAUSE_IDX:
         begin
            rd_nxt[5:0] = cause_r;
            rd_nxt[`RSS_CAUSE_TO] = sfl_r.to;
            rd_nxt[`RSS_CAUSE_PD] = sfl_r.pd;
            rd_nxt[`RSS_CAUSE_HOLD] = core_hold_o;
         end
         default:
            rd_nxt = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= req;
         if (req && !wb_we_i)
            wb_dat_o <= rd_nxt;
      end
   end

endmodule
`default_nettype wire

// File: pkg/rss_defs.svh
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// ----------------------------------------
// clock and oscillator rates
// ----------------------------------------
`define RSS_CLK_HZ 40000000
`define RSS_CLK_PERIOD_NS 25
`define RSS_FAST_HZ 4000000
`define RSS_SLOW_HZ 37000
`define RSS_RC_PERIOD_NS 1000

// ----------------------------------------
// start-up and filter times
// ----------------------------------------
`define RSS_POWERUP_DELAY_TIMER_MS 72
`define RSS_NS_PER_MS 1000000
`define RSS_OST_CYCLES 1024
`define RSS_BOD_MIN_NS 100000
`define RSS_MASTER_CLEAR_PIN_MIN_NS 2000

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define RSS_POWER_CONTROL_STATUS_IDX 10'h08e
`define RSS_CFG_IDX 10'h090
`define RSS_CAUSE_IDX 10'h091

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define RSS_POWER_CONTROL_STATUS_BOD 0
`define RSS_POWER_CONTROL_STATUS_POR 1
`define RSS_POWER_CONTROL_STATUS_SPEED_SELECT_BIT 3
`define RSS_CFG_PWRTD 3
`define RSS_CFG_BROWNOUT_ENABLE_CFG 4
`define RSS_CAUSE_TO 6
`define RSS_CAUSE_PD 7
`define RSS_CAUSE_HOLD 8
`define RSS_CFG_RST 5'h15

`endif

// File: pkg/rss_pkg.sv
`default_nettype none
package rss_pkg;

   // ----------------------------------------
   // oscillator modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      OSC_LP = 3'h0,
      OSC_XT = 3'h1,
      OSC_HS = 3'h2,
      OSC_EC = 3'h3,
      OSC_INTERNAL_RC_MODE_IO = 3'h4,
      OSC_INTERNAL_RC_MODE_CLK = 3'h5,
      OSC_ER_IO = 3'h6,
      OSC_ER_CLK = 3'h7
   } rss_osc_mode_t;

   // ----------------------------------------
   // sequencer states and reset causes
   // ----------------------------------------
   typedef enum logic [5:0] {
      ST_POR = 6'h01,
      ST_BOD = 6'h02,
      ST_POWERUP_DELAY_TIMER = 6'h04,
      ST_OST = 6'h08,
      ST_HOLD = 6'h10,
      ST_RUN = 6'h20
   } rss_state_t;

   typedef enum logic [5:0] {
      CS_POR = 6'h01,
      CS_MASTER_CLEAR_PIN_RUN = 6'h02,
      CS_MASTER_CLEAR_PIN_SLP = 6'h04,
      CS_WDT = 6'h08,
      CS_WAKE = 6'h10,
      CS_BOD = 6'h20
   } rss_cause_t;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic bod_en;
      logic powerup_delay_timer_dis;
      rss_osc_mode_t mode;
   } rss_cfg_t;

   typedef struct packed {
      logic to;
      logic pd;
   } rss_sflags_t;

endpackage
`default_nettype wire

// File: dv/rss_chk.sv
`default_nettype none
module rss_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // pins
   input wire logic supply_ok_i,
   input wire logic master_clear_pin_n_i,
   // outputs
   input wire logic core_hold_o,
   input wire logic regs_reset_o,
   input wire logic wake_o,
   input wire logic sys_tick_o,
   input wire logic sys_slow_o,
   input wire logic crystal_out_pin_o,
   input wire logic crystal_out_pin_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // reset sequencing
   // ----------------------------------------
   reset_hold_a: assert property (disable iff (1'b0) rst_i |=> core_hold_o && regs_reset_o)
      else $error("core not held during reset");
   supply_hold_a: assert property (!supply_ok_i [*5] |=> core_hold_o)
      else $error("core runs with supply low");
   release_master_clear_pin_a: assert property ($fell(core_hold_o) |->
      master_clear_pin_n_i && $past(master_clear_pin_n_i, 8) && supply_ok_i)
      else $error("core released while master clear or supply low");
   regs_hold_a: assert property (regs_reset_o |-> core_hold_o)
      else $error("registers reset while core runs");
   wake_keep_a: assert property (wake_o |-> !regs_reset_o ##1 !wake_o)
      else $error("wake pulse wrong or registers reset on wake");
   // ----------------------------------------
   // clocks and bus
   // ----------------------------------------
   tick_space_a: assert property (sys_tick_o && !sys_slow_o |=> !sys_tick_o [*8])
      else $error("fast tick spacing wrong");
   quarter_tick_a: assert property ($changed(crystal_out_pin_o) && $stable(crystal_out_pin_oe_n_o)
      |-> sys_tick_o || $past(sys_tick_o))
      else $error("clock output moved without a tick");
   pin_release_a: assert property (crystal_out_pin_oe_n_o |-> !crystal_out_pin_o)
      else $error("released pin carries a clock");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acked");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   cover property ($rose(wake_o));
   cover property ($fell(core_hold_o));
   cover property ($changed(crystal_out_pin_o));
endmodule

bind rss_top rss_chk i_rss_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .supply_ok_i(supply_ok_i),
   .master_clear_pin_n_i(master_clear_pin_n_i), .core_hold_o(core_hold_o),
   .regs_reset_o(regs_reset_o), .wake_o(wake_o), .sys_tick_o(sys_tick_o),
   .sys_slow_o(sys_slow_o), .crystal_out_pin_o(crystal_out_pin_o),
   .crystal_out_pin_oe_n_o(crystal_out_pin_oe_n_o));
`default_nettype wire

// File: dv/rss_pin_model.sv
`default_nettype none
module rss_pin_model (
   // clock
   input wire logic clk_i,
   // bench commands
   input wire logic supply_cmd_i,
   input wire logic brown_cmd_i,
   input wire logic master_clear_pin_low_cmd_i,
   input wire logic osc_run_i,
   // device pins
   output logic supply_ok_o,
   output logic brownout_low_o,
   output logic master_clear_pin_n_o,
   output logic crystal_in_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_r;
   assign supply_ok_o = supply_cmd_i;
   assign brownout_low_o = brown_cmd_i;
   // pin sits on a pull-up, so a released master clear reads high
   assign master_clear_pin_n_o = !master_clear_pin_low_cmd_i;
   // crystal stands still while stopped, period of 8 clk when running
   always_ff @(posedge clk_i)
   begin
      if (!osc_run_i)
      begin
         div_r <= 2'h0;
         crystal_in_pin_o <= 1'b0;
      end
      else
      begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3)
            crystal_in_pin_o <= !crystal_in_pin_o;
      end
   end
endmodule
`default_nettype wire

// File: dv/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_POWER_CONTROL_STATUS = 12'h238;
   localparam logic [11:0] A_CFG = 12'h240;
   localparam logic [11:0] A_CAUSE = 12'h244;
   // four RC ticks of 40 clk; the first tick may come early, as the RC divider runs free
   localparam int POWERUP_DELAY_TIMER_CLK = 160;
   logic clk_i, rst_i, cyc, stb, we, wdt, slp, sup, brown, master_clear_pin, osc;
   logic [11:0] adr;
   logic [31:0] dat, dat_o;
   logic ack, ok, bl, mc, xi, hold, rr_o, wake, tick, slow, xo, xoe;
   int fails, checks, n, e, r1, r2;
   logic pv, rr;
   rss_top #(.POWERUP_DELAY_TIMER_RC_CYCLES(4)) i_rss_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .supply_ok_i(ok), .brownout_low_i(bl),
      .master_clear_pin_n_i(mc), .crystal_in_pin_i(xi), .watchdog_expired_i(wdt),
      .core_sleeping_i(slp), .core_hold_o(hold), .regs_reset_o(rr_o), .wake_o(wake),
      .sys_tick_o(tick), .sys_slow_o(slow), .crystal_out_pin_o(xo),
      .crystal_out_pin_oe_n_o(xoe));
   rss_pin_model i_rss_pin_model (.clk_i(clk_i), .supply_cmd_i(sup), .brown_cmd_i(brown),
      .master_clear_pin_low_cmd_i(master_clear_pin), .osc_run_i(osc), .supply_ok_o(ok), .brownout_low_o(bl),
      .master_clear_pin_n_o(mc), .crystal_in_pin_o(xi));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
      input string what);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, x, q & m);
   endtask
   task automatic wait_run(input int lim);
      n = 0;
      while (hold !== 1'b0 && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("core_hold_o", 32'h0, 32'(hold));
   endtask
   task automatic master_clear_pin_reset(input logic s, input logic [31:0] cause);
      slp <= s;
      master_clear_pin <= 1'b1;
      repeat (200) @(posedge clk_i);
      chk("core_hold_o", 32'h1, 32'(hold));
      rd(A_CAUSE, 32'h3f, cause, "cause");
      slp <= 1'b0;
      master_clear_pin <= 1'b0;
      wait_run(300);
   endtask
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = !clk_i;
   end
   initial
   begin
      #1500000;
      fails++;
      summarize();
   end
   initial
   begin
      {rst_i, sup} = 2'h3;
      {cyc, stb, we, wdt, slp, brown, master_clear_pin, osc} = 8'h0;
      adr = 12'h0;
      dat = 32'h0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_run(2000);
      chk("powerup delay", 32'h1, 32'(n > POWERUP_DELAY_TIMER_CLK - 40 && n <= POWERUP_DELAY_TIMER_CLK + 8));
      rd(A_POWER_CONTROL_STATUS, 32'he, 32'h8, "power_control_status");
      rd(A_CFG, 32'h1f, 32'h15, "config");
      rd(A_CAUSE, 32'h3f, 32'h01, "cause");
      rd(12'h3fc, 32'hffffffff, 32'h0, "unmapped");
      wr(A_POWER_CONTROL_STATUS, 32'h0b);
      rd(A_POWER_CONTROL_STATUS, 32'hf, 32'hb, "power_control_status");
      wr(A_POWER_CONTROL_STATUS, 32'h03);
      for (int m = 0; m < 8; m++)
      begin
         wr(A_CFG, 32'h10 | 32'(m));
         repeat (3) @(posedge clk_i);
         chk("oe_n", 32'(m != 5 && m != 7), 32'(xoe));
         chk("sys_slow_o", 32'(m >= 4), 32'(slow));
      end
      wr(A_CFG, 32'h15);
      wr(A_POWER_CONTROL_STATUS, 32'h0b);
      r1 = -1;
      r2 = -1;
      pv = xo;
      for (int i = 0; i < 200; i++)
      begin
         @(posedge clk_i);
         if (xo && !pv && r1 >= 0 && r2 < 0)
            r2 = i;
         if (xo && !pv && r1 < 0)
            r1 = i;
         pv = xo;
      end
      chk("quarter period", 32'd40, 32'(r2 - r1));
      // a short pulse must never show on the hold output, not even briefly
      master_clear_pin <= 1'b1;
      rr = 1'b0;
      for (int i = 0; i < 220; i++)
      begin
         @(posedge clk_i);
         rr |= hold;
         if (i == 19)
            master_clear_pin <= 1'b0;
      end
      chk("core_hold_o", 32'h0, 32'(rr));
      master_clear_pin_reset(1'b0, 32'h02);
      master_clear_pin_reset(1'b1, 32'h04);
      rd(A_POWER_CONTROL_STATUS, 32'h3, 32'h3, "flags");
      brown <= 1'b1;
      repeat (4100) @(posedge clk_i);
      chk("core_hold_o", 32'h1, 32'(hold));
      brown <= 1'b0;
      repeat (100) @(posedge clk_i);
      brown <= 1'b1;
      repeat (4100) @(posedge clk_i);
      brown <= 1'b0;
      wait_run(2000);
      chk("powerup restart", 32'h1, 32'(n > POWERUP_DELAY_TIMER_CLK - 40 && n <= POWERUP_DELAY_TIMER_CLK + 8));
      rd(A_CAUSE, 32'h3f, 32'h20, "cause");
      rd(A_POWER_CONTROL_STATUS, 32'h3, 32'h2, "flags");
      wr(A_POWER_CONTROL_STATUS, 32'h0b);
      wdt <= 1'b1;
      @(posedge clk_i);
      wdt <= 1'b0;
      repeat (20) @(posedge clk_i);
      rd(A_CAUSE, 32'h3f, 32'h08, "cause");
      wr(A_CFG, 32'h11);
      wr(A_POWER_CONTROL_STATUS, 32'h03);
      osc <= 1'b1;
      slp <= 1'b1;
      repeat (2) @(posedge clk_i);
      wdt <= 1'b1;
      @(posedge clk_i);
      wdt <= 1'b0;
      {e, n, rr, pv} = '0;
      while (wake !== 1'b1 && n < 20000)
      begin
         @(posedge clk_i);
         n++;
         e += int'(xi && !pv);
         pv = xi;
         rr |= rr_o;
      end
      slp <= 1'b0;
      chk("settle edges", 32'h1, 32'(e >= 1024 && e <= 1040));
      chk("regs_reset_o", 32'h0, 32'(rr));
      wait_run(300);
      rd(A_POWER_CONTROL_STATUS, 32'h8, 32'h0, "speed bit");
      rd(A_CAUSE, 32'h3f, 32'h10, "cause");
      wr(A_CFG, 32'h15);
      osc <= 1'b0;
      sup <= 1'b0;
      repeat (10) @(posedge clk_i);
      sup <= 1'b1;
      wait_run(3000);
      chk("powerup delay", 32'h1, 32'(n > POWERUP_DELAY_TIMER_CLK - 40 && n <= POWERUP_DELAY_TIMER_CLK + 8));
      rd(A_POWER_CONTROL_STATUS, 32'h2, 32'h0, "power-on flag");
      summarize();
   end
endmodule
`default_nettype wire
